// ===== logic/csie_regs.sv
// Calibration status, interrupt enable, lot code and test setting registers.
// Assumes the serial port decodes transfers into one-cycle read/write strobes
// and that event inputs are single-cycle pulses synchronous to clk_sys.
`timescale 1ns/10ps
module csie_regs #(
    parameter logic [7:0] LOT_LOW  = 8'h00,
    parameter logic [7:0] LOT_HIGH = 8'h00
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic       autodecEnable,
    input  wire logic       nearResultZero,
    input  wire logic       calFinished,
    input  wire logic [7:0] calOffsetResult,
    input  wire logic       offsetWrite,
    input  wire logic [7:0] offsetWdata,
    input  wire logic       calFlagClear,
    input  wire logic [5:0] eventFlags,
    output logic      [7:0] nearOffsetLow,
    output logic            calInterruptFlag,
    output logic            irqOut
);
    logic       autodecFlag;
    logic       next_autodecFlag;
    logic       calFlag;
    logic       next_calFlag;
    logic [7:0] irqEnables;
    logic [7:0] next_irqEnables;
    logic [7:0] testSetting;
    logic [7:0] next_testSetting;
    logic [7:0] offsetLow;
    logic [7:0] next_offsetLow;
    logic [7:0] next_regRdata;
    logic       autodecEnPrev;
    logic       decEvent;
    logic       wrStatus;
    logic       wrEnables;
    logic [5:0] flagsAll;

    assign wrStatus  = regWrite && regAddr == csie_pkg::ADDR_CAL_STATUS;
    assign wrEnables = regWrite && regAddr == csie_pkg::ADDR_IRQ_ENABLES;
    // Saturating at zero: an offset already at zero cannot go lower
    assign decEvent  = autodecEnable && nearResultZero
                       && offsetLow != 8'h00;

    always_comb begin
        next_offsetLow   = offsetLow;
        next_calFlag     = calFlag;
        next_autodecFlag = autodecFlag;
        next_irqEnables  = irqEnables;
        next_testSetting = testSetting;
        if (offsetWrite) begin
            next_offsetLow = offsetWdata;
        end
        if (decEvent) begin
            next_offsetLow = offsetLow - 8'h01;
        end
        if (calFinished) begin
            next_offsetLow = calOffsetResult;
        end
        if (calFlagClear) begin
            next_calFlag = 1'b0;
        end
        if (calFinished) begin
            next_calFlag = 1'b1;
        end
        if (wrStatus && regWdata[csie_pkg::BIT_AUTODEC_FLAG]) begin
            next_autodecFlag = 1'b0;
        end
        if (autodecEnPrev && !autodecEnable) begin
            next_autodecFlag = 1'b0;
        end
        // Set wins over a same-cycle clear
        if (decEvent) begin
            next_autodecFlag = 1'b1;
        end
        if (wrEnables) begin
            // Reserved low bits are kept at zero
            next_irqEnables = regWdata
                              & csie_pkg::IRQ_ENABLE_MASK;
        end
        if (regWrite && regAddr == csie_pkg::ADDR_TEST_SETTING) begin
            next_testSetting = regWdata;
        end
    end

    always_comb begin
        next_regRdata = regRdata;
        if (regRead) begin
            case (regAddr)
                csie_pkg::ADDR_CAL_STATUS:
                    next_regRdata = {5'h00, autodecFlag, 1'b0,
                                     calFlag};
                csie_pkg::ADDR_IRQ_ENABLES:
                    next_regRdata = irqEnables;
                csie_pkg::ADDR_LOT_LOW:
                    next_regRdata = LOT_LOW;
                csie_pkg::ADDR_LOT_HIGH:
                    next_regRdata = LOT_HIGH;
                csie_pkg::ADDR_TEST_SETTING:
                    next_regRdata = testSetting;
                default:
                    next_regRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            offsetLow     <= csie_pkg::RST_OFFSET_LOW;
            calFlag       <= 1'b0;
            autodecFlag   <= 1'b0;
            irqEnables    <= csie_pkg::RST_IRQ_ENABLES;
            testSetting   <= csie_pkg::RST_TEST_SETTING;
            regRdata      <= 8'h00;
            autodecEnPrev <= 1'b0;
        end else begin
            offsetLow     <= next_offsetLow;
            calFlag       <= next_calFlag;
            autodecFlag   <= next_autodecFlag;
            irqEnables    <= next_irqEnables;
            testSetting   <= next_testSetting;
            regRdata      <= next_regRdata;
            autodecEnPrev <= autodecEnable;
        end
    end

    // Order: light sat, near sat, near thresh, light, cal, zero
    assign flagsAll = {eventFlags[5:2], calFlag, eventFlags[0]};
    assign nearOffsetLow    = offsetLow;
    assign calInterruptFlag = calFlag;
    assign irqOut = |(flagsAll & irqEnables[7:2]);

    a_autodec_set: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        decEvent |=> autodecFlag)
        else $error("autodec flag not set");
    a_autodec_w1c: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wrStatus && regWdata[csie_pkg::BIT_AUTODEC_FLAG] && !decEvent
        |=> !autodecFlag)
        else $error("autodec flag not cleared by write");
    a_autodec_disable: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        autodecEnPrev && !autodecEnable |=> !autodecFlag)
        else $error("autodec flag not cleared on disable");
    a_cal_mirror: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        regRead && regAddr == csie_pkg::ADDR_CAL_STATUS
        |=> regRdata[csie_pkg::BIT_CAL_DONE] == $past(calFlag))
        else $error("cal copy mismatch");
    a_cal_clear: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        calFlagClear && !calFinished |=> !calInterruptFlag)
        else $error("cal flag not cleared");
    a_enable_store: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wrEnables
        |=> irqEnables == ($past(regWdata) & csie_pkg::IRQ_ENABLE_MASK))
        else $error("enables not stored");
    a_enable_rsvd: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        irqEnables[1:0] == 2'b00)
        else $error("reserved enable bits set");
    a_status_rsvd: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        regRead && regAddr == csie_pkg::ADDR_CAL_STATUS
        |=> regRdata[7:3] == 5'h00 && regRdata[1] == 1'b0)
        else $error("reserved status bits not zero");
    a_lot_readonly: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        regRead && regAddr == csie_pkg::ADDR_LOT_HIGH
        |=> regRdata == LOT_HIGH)
        else $error("lot code byte changed");
    a_test_store: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        regWrite && regAddr == csie_pkg::ADDR_TEST_SETTING
        |=> testSetting == $past(regWdata))
        else $error("test setting not stored");
    a_offset_dec: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        decEvent && !calFinished && !offsetWrite
        |=> nearOffsetLow == $past(nearOffsetLow) - 8'h01)
        else $error("offset not decremented");
    a_offset_floor: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        nearOffsetLow == 8'h00 && !calFinished && !offsetWrite
        |=> nearOffsetLow == 8'h00)
        else $error("offset went below zero");
    a_cal_load: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        calFinished |=> calInterruptFlag
        && nearOffsetLow == $past(calOffsetResult))
        else $error("calibration result not loaded");
    a_irq_gate: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        irqOut == ((irqEnables[csie_pkg::BIT_LIGHT_SAT] && eventFlags[5])
                   || (irqEnables[csie_pkg::BIT_NEAR_SAT] && eventFlags[4])
                   || (irqEnables[csie_pkg::BIT_NEAR_THRESH] && eventFlags[3])
                   || (irqEnables[csie_pkg::BIT_LIGHT] && eventFlags[2])
                   || (irqEnables[csie_pkg::BIT_CAL] && calInterruptFlag)
                   || (irqEnables[csie_pkg::BIT_ZERO] && eventFlags[0])))
        else $error("irq gating wrong");

    c_autodec: cover property (@(posedge clk_sys) disable iff (!rstn)
        decEvent ##1 wrStatus);
    c_cal_irq: cover property (@(posedge clk_sys) disable iff (!rstn)
        calFinished ##1 irqOut);
    c_test_write: cover property (@(posedge clk_sys) disable iff (!rstn)
        regWrite && regAddr == csie_pkg::ADDR_TEST_SETTING
        && regWdata == 8'hc4);
    c_masked_cal: cover property (@(posedge clk_sys) disable iff (!rstn)
        calFinished && !irqEnables[csie_pkg::BIT_CAL]);
    c_autodec_off: cover property (@(posedge clk_sys) disable iff (!rstn)
        autodecFlag && autodecEnPrev && !autodecEnable);
endmodule

// ===== logic/csie_pkg.sv
// Constants for the calibration status / interrupt enable register slice.
// Assumes an 8-bit internal register port fed by the serial interface.
package csie_pkg;
    localparam logic [7:0] ADDR_CAL_STATUS   = 8'hdc;
    localparam logic [7:0] ADDR_IRQ_ENABLES  = 8'hdd;
    localparam logic [7:0] ADDR_LOT_LOW      = 8'he6;
    localparam logic [7:0] ADDR_LOT_HIGH     = 8'he7;
    localparam logic [7:0] ADDR_TEST_SETTING = 8'hf2;
    localparam int         BIT_AUTODEC_FLAG  = 2;
    localparam int         BIT_CAL_DONE      = 0;
    localparam int         BIT_LIGHT_SAT     = 7;
    localparam int         BIT_NEAR_SAT      = 6;
    localparam int         BIT_NEAR_THRESH   = 5;
    localparam int         BIT_LIGHT         = 4;
    localparam int         BIT_CAL           = 3;
    localparam int         BIT_ZERO          = 2;
    localparam logic [7:0] IRQ_ENABLE_MASK   = 8'hfc;
    localparam logic [7:0] RST_IRQ_ENABLES   = 8'h00;
    localparam logic [7:0] RST_TEST_SETTING  = 8'h44;
    localparam logic [7:0] RST_OFFSET_LOW    = 8'h00;
endpackage

// ===== testbench/csie_host.sv
// Host model: single-byte register accesses on the strobe port.
// Assumes clk_sys runs free; signals change 1 ns after a rising edge.
`timescale 1ns/10ps
module csie_host (
    input  wire logic       clk_sys,
    input  wire logic [7:0] regRdata,
    output logic            regWrite = 1'b0,
    output logic            regRead = 1'b0,
    output logic      [7:0] regAddr = 8'h00,
    output logic      [7:0] regWdata = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        regAddr = a;
        regWdata = d;
        if (a == csie_pkg::ADDR_CAL_STATUS)
            regWdata = d & 8'h05;
        if (a == csie_pkg::ADDR_IRQ_ENABLES)
            regWdata = d & csie_pkg::IRQ_ENABLE_MASK;
        regWrite = 1'b1;
        @(posedge clk_sys) #1;
        regWrite = 1'b0;
        // Released data must not look like the last byte
        regWdata = ~regWdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk_sys) #1;
        regRead = 1'b0;
        // Data is registered on the strobe edge and holds until the next read
        d = regRdata;
    endtask
endmodule

// ===== testbench/calib_status_irq_enable_regs_tb_top.sv
// Bench for the calibration status and interrupt enable registers.
// Assumes csie_host makes all register accesses.
`timescale 1ns/10ps
module calib_status_irq_enable_regs_tb_top;
    logic       clk_sys = 1'b0, rstn = 1'b0;
    logic       regWrite, regRead, irqOut, calInterruptFlag;
    logic [7:0] regAddr, regWdata, regRdata, nearOffsetLow;
    logic       autodecEnable = 1'b0, nearResultZero = 1'b0;
    logic       calFinished = 1'b0, calFlagClear = 1'b0;
    logic [7:0] calOffsetResult = 8'h00;
    logic       offsetWrite = 1'b0;
    logic [7:0] offsetWdata = 8'h00;
    logic [5:0] eventFlags = 6'h00;
    int         errors = 0, compares = 0, cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    // Lot code values are arbitrary
    csie_regs #(.LOT_LOW(8'h5a), .LOT_HIGH(8'ha5)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .autodecEnable(autodecEnable),
        .nearResultZero(nearResultZero), .calFinished(calFinished),
        .calOffsetResult(calOffsetResult), .offsetWrite(offsetWrite),
        .offsetWdata(offsetWdata), .calFlagClear(calFlagClear),
        .eventFlags(eventFlags), .nearOffsetLow(nearOffsetLow),
        .calInterruptFlag(calInterruptFlag), .irqOut(irqOut));
    csie_host u_host (.clk_sys(clk_sys), .regRdata(regRdata),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata));
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk("regRdata", e, d);
    endtask
    task automatic tick();
        @(posedge clk_sys) #1;
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rstn = 1'b1;
        rchk(8'hdc, 8'h00);
        rchk(8'hdd, 8'h00);
        rchk(8'hf2, 8'h44);
        rchk(8'he6, 8'h5a);
        u_host.wr(8'he7, 8'h00);
        rchk(8'he7, 8'ha5);
        u_host.wr(8'hf2, 8'hc4);
        rchk(8'hf2, 8'hc4);
        for (int i = 2; i < 8; i++) begin
            u_host.wr(8'hdd, 8'h01 << i);
            rchk(8'hdd, 8'h01 << i);
            eventFlags = ~(6'h01 << (i - 2));
            tick();
            chk("irqOut", 8'h00, {7'h0, irqOut});
            eventFlags = 6'h01 << (i - 2);
            tick();
            chk("irqOut", {7'h0, i != 3}, {7'h0, irqOut});
        end
        // Calibration completes while its enable is still off
        eventFlags = 6'h00;
        calOffsetResult = 8'h07;
        calFinished = 1'b1;
        tick();
        calFinished = 1'b0;
        tick();
        chk("nearOffsetLow", 8'h07, nearOffsetLow);
        chk("calInterruptFlag", 8'h01, {7'h0, calInterruptFlag});
        chk("irqOut", 8'h00, {7'h0, irqOut});
        u_host.wr(8'hdd, 8'h08);
        chk("irqOut", 8'h01, {7'h0, irqOut});
        rchk(8'hdc, 8'h01);
        calFlagClear = 1'b1;
        tick();
        calFlagClear = 1'b0;
        rchk(8'hdc, 8'h00);
        chk("calInterruptFlag", 8'h00, {7'h0, calInterruptFlag});
        autodecEnable = 1'b1;
        for (int k = 0; k < 2; k++) begin
            nearResultZero = 1'b1;
            tick();
            nearResultZero = 1'b0;
            tick();
            chk("nearOffsetLow", 8'(6 - k), nearOffsetLow);
            rchk(8'hdc, 8'h04);
            u_host.wr(8'hdc, 8'h00);
            rchk(8'hdc, 8'h04);
            if (k == 0) begin
                u_host.wr(8'hdc, 8'h04);
                rchk(8'hdc, 8'h00);
            end
        end
        autodecEnable = 1'b0;
        rchk(8'hdc, 8'h00);
        // Offset of one decrements once, then rests at zero
        offsetWdata = 8'h01;
        offsetWrite = 1'b1;
        tick();
        offsetWrite = 1'b0;
        chk("nearOffsetLow", 8'h01, nearOffsetLow);
        autodecEnable = 1'b1;
        nearResultZero = 1'b1;
        tick();
        tick();
        nearResultZero = 1'b0;
        chk("nearOffsetLow", 8'h00, nearOffsetLow);
        rchk(8'hdc, 8'h04);
        // Reset in mid-run must bring back the status, enable and test setting reset values
        rstn = 1'b0;
        autodecEnable = 1'b0;
        tick();
        tick();
        rstn = 1'b1;
        chk("irqOut", 8'h00, {7'h0, irqOut});
        rchk(8'hdc, 8'h00);
        rchk(8'hdd, 8'h00);
        rchk(8'hf2, 8'h44);
        complete_run();
    end
endmodule
